// *** coproc_issue_stall_timing.sv ***
// Contract
// - Hold instruction issue while resource stays busy
// - Destination updated exactly latency cycles after issue
// - Latency one result seen by next instruction
// - Basic arithmetic ops: no stall, latency six
// - Reciprocal stalls ten, latency 17; accumulate nine
// - Inverse square root stalls 16, latency 22
// - Pack and unpack stalls and latencies per op
// - Jump: no stall, new counter two cycles later
// - Lane select governs the very next instruction
// - Barrier holds issue until transfers are done
// - Halt updates status after pipeline flush
// - Halt inside accumulate chain waits chain end
// - Halt elsewhere waits current instruction completion
// - Halt stops execution and reports idle
module coproc_issue_stall_timing #(
  parameter int PC_W = 16 // Program counter width
) (
  input wire logic core_clk_i, // Core clock, 25 MHz
  input wire logic rst_i, // Sync reset, high
  input wire logic start_i, // Begin running, pulse
  input wire logic [PC_W-1:0] start_pc_i, // Entry address
  input wire logic [31:0] instr_i, // Word at pc_o
  input wire logic instr_valid_i, // Word is ready
  input wire logic jump_taken_i, // Jump condition met
  input wire logic xfer_busy_i, // Global transfers pending
  output logic [PC_W-1:0] pc_o, // Fetch address
  output logic issue_valid_o, // Instruction issued
  output logic issue_hold_o, // Issue held back
  output logic [coproc_timing_pkg::NUM_CLS-1:0] wb_valid_o, // Updates
  output logic [coproc_timing_pkg::NUM_CLS*coproc_timing_pkg::REG_W-1:0] wb_dst_o, // Targets
  output logic [coproc_timing_pkg::LANES-1:0] lane_mask_o, // Active lanes
  output logic idle_o // Status idle
);

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_BARRIER,
    ST_HALT_SLOT,
    ST_HALT_FLUSH
  } seq_state_t;

  localparam logic [PC_W-1:0] PC_STEP = PC_W'(1); // Sequential advance

  // Control state
  seq_state_t state; // Sequencer state
  seq_state_t next_state;
  logic [PC_W-1:0] pc; // Program counter
  logic [PC_W-1:0] next_pc;
  logic jump_pend; // Taken jump awaiting its slot
  logic next_jump_pend;
  logic [PC_W-1:0] jump_tgt; // Pending jump target
  logic [PC_W-1:0] next_jump_tgt;
  logic [coproc_timing_pkg::LANES-1:0] lane_mask; // Lane select register
  logic [coproc_timing_pkg::LANES-1:0] next_lane_mask;
  logic [1:0] move_cnt; // Guard after a transfer issue
  logic [1:0] next_move_cnt;
  logic [2:0] chain_cnt; // Open accumulate chain window
  logic [2:0] next_chain_cnt;
  logic idle; // Status idle flag
  logic next_idle;

  // Decode and handshake terms
  logic [coproc_timing_pkg::OPC_W-1:0] op; // Opcode of word at pc
  logic issuing_state; // State that may issue
  logic issue; // Word issues this cycle
  logic flushed; // Nothing left in flight
  logic barrier_done; // Transfers all finished
  logic [coproc_timing_pkg::NUM_CLS-1:0] timer_busy; // Per-class flight

  issue_if link(); // Issue event to timers and counter

  assign op = instr_i[coproc_timing_pkg::OPC_LSB +: coproc_timing_pkg::OPC_W];

  // Issue only when running, word ready and no stall pending
  assign issuing_state = (state == ST_RUN) || (state == ST_HALT_SLOT);
  assign issue = issuing_state && instr_valid_i && !link.stall_busy;

  // Decoded attributes of the issuing word
  assign link.valid = issue;
  assign link.cls = coproc_timing_pkg::class_of(op);
  assign link.dst = instr_i[coproc_timing_pkg::DST_LSB +: coproc_timing_pkg::REG_W];
  assign link.stall_load = coproc_timing_pkg::stall_of(op);

  // Stalled-cycle counter
  stall_counter u_stall (
    .core_clk_i (core_clk_i),
    .rst_i (rst_i),
    .port (link.staller)
  );

  // One exact-latency timer per result class
  generate
    for (genvar g = 0; g < coproc_timing_pkg::NUM_CLS; g++)
    begin : g_timer
      result_timer #(
        .LATENCY (coproc_timing_pkg::class_latency(g)),
        .CLASS (coproc_timing_pkg::CLS_W'(g))
      ) u_timer (
        .core_clk_i (core_clk_i),
        .rst_i (rst_i),
        .port (link.timer),
        .wb_valid_o (wb_valid_o[g]),
        .wb_dst_o (wb_dst_o[g*coproc_timing_pkg::REG_W +: coproc_timing_pkg::REG_W]),
        .busy_o (timer_busy[g])
      );
    end
  endgenerate

  // Flush covers stalls, in-flight results and an open chain
  assign flushed = !link.stall_busy && (timer_busy == '0)
                   && (chain_cnt == '0);

  // Transfer engine gets a short guard to raise its busy
  assign barrier_done = !xfer_busy_i && (move_cnt == '0);

  // Hold toward the instruction RAM; bubbles go down the pipe
  assign issue_hold_o = (issuing_state && link.stall_busy)
                        || (state == ST_BARRIER)
                        || (state == ST_HALT_FLUSH);

  assign issue_valid_o = issue;

  // Next values of all sequencing state
  always_comb
  begin
    next_state = state;
    next_pc = pc;
    next_jump_pend = jump_pend;
    next_jump_tgt = jump_tgt;
    next_lane_mask = lane_mask;
    next_idle = idle;
    // Guard and chain windows run down every cycle
    next_move_cnt = (move_cnt != '0) ? move_cnt - 2'h1 : move_cnt;
    next_chain_cnt = (chain_cnt != '0) ? chain_cnt - 3'h1 : chain_cnt;

    case (state)
      // Stopped; wait for a start
      ST_IDLE:
      begin
        if (start_i)
        begin
          next_state = ST_RUN;
          next_pc = start_pc_i;
          next_jump_pend = 1'b0;
          next_idle = 1'b0;
        end
      end
      // Normal issue; barrier and halt change state
      ST_RUN:
      begin
        if (issue && op == coproc_timing_pkg::BARRIER_OP)
          next_state = ST_BARRIER;
        else if (issue && op == coproc_timing_pkg::HALT_OP)
          next_state = ST_HALT_SLOT;
      end
      // Variable stall until transfers drain
      ST_BARRIER:
      begin
        if (barrier_done)
          next_state = ST_RUN;
      end
      // Word after a halt still executes
      ST_HALT_SLOT:
      begin
        if (issue)
          next_state = ST_HALT_FLUSH;
      end
      // Status waits for the flush
      ST_HALT_FLUSH:
      begin
        if (flushed)
        begin
          next_state = ST_IDLE;
          next_idle = 1'b1;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase

    // Effects of the issuing word; counter frozen otherwise
    if (issue)
    begin
      // Jump delay slot: target taken after the next issue
      next_pc = jump_pend ? jump_tgt : pc + PC_STEP;
      next_jump_pend = 1'b0;
      if (op == coproc_timing_pkg::CONDITIONAL_JUMP_OP && jump_taken_i)
      begin
        next_jump_pend = 1'b1;
        next_jump_tgt = PC_W'(instr_i[coproc_timing_pkg::TGT_LSB +: coproc_timing_pkg::TGT_W]);
      end
      // Mask valid for the very next word
      if (op == coproc_timing_pkg::LANE_SELECT_OP)
        next_lane_mask = instr_i[coproc_timing_pkg::MASK_LSB +: coproc_timing_pkg::LANES];
      // Transfer engine may lag a little in raising busy
      if (op == coproc_timing_pkg::GLOBAL_LOAD_OP || op == coproc_timing_pkg::GLOBAL_STORE_OP)
        next_move_cnt = coproc_timing_pkg::MOVE_GUARD;
      // Start opens a window that runs down over four cycles
      if (op == coproc_timing_pkg::MULT_ACCUM_START_OP)
        next_chain_cnt = coproc_timing_pkg::CHAIN_SLOTS;
    end
  end

  // Register only
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state <= ST_IDLE;
      pc <= '0;
      jump_pend <= 1'b0;
      jump_tgt <= '0;
      lane_mask <= coproc_timing_pkg::LANE_RESET;
      move_cnt <= '0;
      chain_cnt <= '0;
      idle <= 1'b1;
    end
    else
    begin
      state <= next_state;
      pc <= next_pc;
      jump_pend <= next_jump_pend;
      jump_tgt <= next_jump_tgt;
      lane_mask <= next_lane_mask;
      move_cnt <= next_move_cnt;
      chain_cnt <= next_chain_cnt;
      idle <= next_idle;
    end
  end

  assign pc_o = pc;
  assign lane_mask_o = lane_mask;
  assign idle_o = idle;

  // Reciprocal: ten held cycles with no issue
  property p_recip_stall;
    @(posedge core_clk_i) disable iff (rst_i)
    (issue && op == coproc_timing_pkg::RECIPROCAL_OP)
      |=> (!issue_valid_o && issue_hold_o) [*8]
      ##1 (!issue_valid_o && issue_hold_o)
      ##1 (!issue_valid_o && issue_hold_o);
  endproperty
  a_recip_stall: assert property (p_recip_stall)
    else $error("reciprocal did not hold issue ten cycles");

  // Inverse square root: sixteen held cycles
  property p_sqrt_stall;
    @(posedge core_clk_i) disable iff (rst_i)
    (issue && op == coproc_timing_pkg::INV_SQUARE_ROOT_OP)
      |=> (!issue_valid_o) [*8] ##1 (!issue_valid_o) [*8];
  endproperty
  a_sqrt_stall: assert property (p_sqrt_stall)
    else $error("inverse square root did not hold sixteen cycles");

  // Add: update six cycles on with the issued target
  property p_basic_latency;
    @(posedge core_clk_i) disable iff (rst_i)
    (issue && op == coproc_timing_pkg::ADD_OP)
      |-> ##6 (wb_valid_o[0] && wb_dst_o[7:0] == $past(instr_i[15:8], 6));
  endproperty
  a_basic_latency: assert property (p_basic_latency)
    else $error("add result not updated after six cycles");

  // Accumulate: no stall, update nine cycles on
  property p_mult_accum_op_latency;
    @(posedge core_clk_i) disable iff (rst_i)
    (issue && op == coproc_timing_pkg::MULT_ACCUM_OP)
      |-> ##1 !link.stall_busy ##8 wb_valid_o[2];
  endproperty
  a_mult_accum_op_latency: assert property (p_mult_accum_op_latency)
    else $error("accumulate result not updated after nine cycles");

  // Three-byte pack: one held cycle, update seven on
  property p_pack3;
    @(posedge core_clk_i) disable iff (rst_i)
    (issue && op == coproc_timing_pkg::PACK_THREE_BYTES_OP)
      |=> (issue_hold_o && !issue_valid_o) ##6 wb_valid_o[1];
  endproperty
  a_pack3: assert property (p_pack3)
    else $error("three-byte pack timing wrong");

  // Taken jump: target in the counter two cycles after issue
  property p_jump_target;
    @(posedge core_clk_i) disable iff (rst_i)
    (issue && op == coproc_timing_pkg::CONDITIONAL_JUMP_OP && jump_taken_i)
      ##1 issue_valid_o
      |=> (pc_o == PC_W'($past(instr_i[23:8], 2)));
  endproperty
  a_jump_target: assert property (p_jump_target)
    else $error("jump target not reached two cycles after issue");

  // Lane select governs the next word
  property p_lane_next;
    @(posedge core_clk_i) disable iff (rst_i)
    (issue && op == coproc_timing_pkg::LANE_SELECT_OP)
      |=> (lane_mask_o == $past(instr_i[11:8]));
  endproperty
  a_lane_next: assert property (p_lane_next)
    else $error("lane mask not in place for the next word");

  // Barrier: no issue while transfers remain
  property p_barrier_wait;
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_BARRIER && xfer_busy_i) |=> !issue_valid_o;
  endproperty
  a_barrier_wait: assert property (p_barrier_wait)
    else $error("issue during barrier with transfers pending");

  // Halt: idle only after the flush, then nothing issues
  property p_halt_flush;
    @(posedge core_clk_i) disable iff (rst_i)
    (state == ST_HALT_FLUSH) |=> (idle_o == $past(flushed)) && (!idle_o || !issue_valid_o);
  endproperty
  a_halt_flush: assert property (p_halt_flush)
    else $error("halt status not tied to pipeline flush");

  // Stall freezes the program counter
  property p_stall_freeze;
    @(posedge core_clk_i) disable iff (rst_i)
    (issuing_state && link.stall_busy) |=> $stable(pc_o);
  endproperty
  a_stall_freeze: assert property (p_stall_freeze)
    else $error("program counter moved during a stall");

endmodule : coproc_issue_stall_timing

// *** coproc_timing_pkg.sv ***
package coproc_timing_pkg;

  // Datapath and field widths
  localparam int OPC_W = 8;
  localparam int INSTR_W = 32;
  localparam int REG_W = 8;
  localparam int LANES = 4;
  localparam int STALL_W = 5;
  localparam int CLS_W = 3;
  localparam int NUM_CLS = 5;

  // Instruction field positions
  localparam int OPC_LSB = 0;
  localparam int DST_LSB = 8;
  localparam int TGT_LSB = 8;
  localparam int TGT_W = 16;
  localparam int MASK_LSB = 8;

  // Opcode encodings
  localparam logic [OPC_W-1:0] NOOP_OP = 8'h00;
  localparam logic [OPC_W-1:0] ADD_OP = 8'h01;
  localparam logic [OPC_W-1:0] SUB_OP = 8'h02;
  localparam logic [OPC_W-1:0] MUL_OP = 8'h03;
  localparam logic [OPC_W-1:0] RECIPROCAL_OP = 8'h04;
  localparam logic [OPC_W-1:0] MULT_ACCUM_OP = 8'h05;
  localparam logic [OPC_W-1:0] MULT_ACCUM_START_OP = 8'h06;
  localparam logic [OPC_W-1:0] INV_SQUARE_ROOT_OP = 8'h07;
  localparam logic [OPC_W-1:0] FLOAT_TO_INT_OP = 8'h08;
  localparam logic [OPC_W-1:0] INT_TO_FLOAT_OP = 8'h09;
  localparam logic [OPC_W-1:0] PACK_TWO_HALVES_OP = 8'h0a;
  localparam logic [OPC_W-1:0] PACK_THREE_BYTES_OP = 8'h0b;
  localparam logic [OPC_W-1:0] UNPACK_TWO_HALVES_OP = 8'h0c;
  localparam logic [OPC_W-1:0] UNPACK_THREE_BYTES_OP = 8'h0d;
  localparam logic [OPC_W-1:0] COMPARE_GREATER_OP = 8'h0e;
  localparam logic [OPC_W-1:0] COMPARE_LESS_EQUAL_OP = 8'h0f;
  localparam logic [OPC_W-1:0] COMPARE_EQUAL_OP = 8'h10;
  localparam logic [OPC_W-1:0] CONDITIONAL_JUMP_OP = 8'h11;
  localparam logic [OPC_W-1:0] CONDITIONAL_COPY_OP = 8'h12;
  localparam logic [OPC_W-1:0] GLOBAL_LOAD_OP = 8'h13;
  localparam logic [OPC_W-1:0] GLOBAL_STORE_OP = 8'h14;
  localparam logic [OPC_W-1:0] BARRIER_OP = 8'h15;
  localparam logic [OPC_W-1:0] LANE_SELECT_OP = 8'h16;
  localparam logic [OPC_W-1:0] HALT_OP = 8'h17;

  // Stalled issue cycles
  localparam logic [STALL_W-1:0] STALL_NONE = 5'h00;
  localparam logic [STALL_W-1:0] STALL_RECIP = 5'h0a;
  localparam logic [STALL_W-1:0] STALL_INV_SQRT = 5'h10;
  localparam logic [STALL_W-1:0] STALL_PACK3 = 5'h01;
  localparam logic [STALL_W-1:0] STALL_UNPACK2 = 5'h01;
  localparam logic [STALL_W-1:0] STALL_UNPACK3 = 5'h02;

  // Result latencies in cycles
  localparam int LAT_BASIC = 6;
  localparam int LAT_PACK3 = 7;
  localparam int LAT_MULT_ACCUM_OP = 9;
  localparam int LAT_RECIP = 17;
  localparam int LAT_INV_SQRT = 22;

  // Accumulate chain window and transfer guard
  localparam logic [2:0] CHAIN_SLOTS = 3'h4;
  localparam logic [1:0] MOVE_GUARD = 2'h2;
  localparam logic [LANES-1:0] LANE_RESET = 4'hf;

  // Result latency classes, one timer each
  localparam logic [CLS_W-1:0] CLS_6 = 3'h0;
  localparam logic [CLS_W-1:0] CLS_7 = 3'h1;
  localparam logic [CLS_W-1:0] CLS_9 = 3'h2;
  localparam logic [CLS_W-1:0] CLS_17 = 3'h3;
  localparam logic [CLS_W-1:0] CLS_22 = 3'h4;
  localparam logic [CLS_W-1:0] CLS_NONE = 3'h7;

  function automatic int class_latency(input int c);
    case (c)
      0: return LAT_BASIC;
      1: return LAT_PACK3;
      2: return LAT_MULT_ACCUM_OP;
      3: return LAT_RECIP;
      default: return LAT_INV_SQRT;
    endcase
  endfunction : class_latency

  function automatic logic [STALL_W-1:0] stall_of(input logic [OPC_W-1:0] op);
    case (op)
      RECIPROCAL_OP: return STALL_RECIP;
      INV_SQUARE_ROOT_OP: return STALL_INV_SQRT;
      PACK_THREE_BYTES_OP: return STALL_PACK3;
      UNPACK_TWO_HALVES_OP: return STALL_UNPACK2;
      UNPACK_THREE_BYTES_OP: return STALL_UNPACK3;
      default: return STALL_NONE;
    endcase
  endfunction : stall_of

  function automatic logic [CLS_W-1:0] class_of(input logic [OPC_W-1:0] op);
    case (op)
      ADD_OP, SUB_OP, MUL_OP, FLOAT_TO_INT_OP, INT_TO_FLOAT_OP,
      PACK_TWO_HALVES_OP, COMPARE_GREATER_OP, COMPARE_LESS_EQUAL_OP,
      COMPARE_EQUAL_OP, CONDITIONAL_COPY_OP: return CLS_6;
      PACK_THREE_BYTES_OP, UNPACK_TWO_HALVES_OP: return CLS_7;
      MULT_ACCUM_OP, UNPACK_THREE_BYTES_OP: return CLS_9;
      RECIPROCAL_OP: return CLS_17;
      INV_SQUARE_ROOT_OP: return CLS_22;
      default: return CLS_NONE;
    endcase
  endfunction : class_of

endpackage : coproc_timing_pkg

// *** issue_if.sv ***
interface issue_if;
  // Issue event and its decoded attributes
  logic valid;
  logic [coproc_timing_pkg::CLS_W-1:0] cls;
  logic [coproc_timing_pkg::REG_W-1:0] dst;
  logic [coproc_timing_pkg::STALL_W-1:0] stall_load;
  logic stall_busy;

  modport issuer (output valid, cls, dst, stall_load, input stall_busy);
  modport timer (input valid, cls, dst);
  modport staller (input valid, stall_load, output stall_busy);
endinterface : issue_if

// *** stall_counter.sv ***
module stall_counter (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_i, // Sync reset, high
  issue_if.staller port // Issue side
);
  logic [coproc_timing_pkg::STALL_W-1:0] cnt; // Cycles still held
  logic [coproc_timing_pkg::STALL_W-1:0] next_cnt;

  // Load on issue, count down while held
  always_comb
  begin
    next_cnt = cnt;
    if (port.valid)
      next_cnt = port.stall_load;
    else if (cnt != '0)
      next_cnt = cnt - 5'h01;
  end

  // Register only
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      cnt <= '0;
    else
      cnt <= next_cnt;
  end

  assign port.stall_busy = (cnt != '0);

  property p_load_holds;
    @(posedge core_clk_i) disable iff (rst_i)
    (port.valid && port.stall_load != '0) |=> port.stall_busy;
  endproperty
  a_load_holds: assert property (p_load_holds)
    else $error("stall load did not hold issue");
endmodule : stall_counter

// *** result_timer.sv ***
module result_timer #(
  parameter int LATENCY = 6, // Cycles from issue to update
  parameter logic [coproc_timing_pkg::CLS_W-1:0] CLASS = 3'h0 // Class served
) (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_i, // Sync reset, high
  issue_if.timer port, // Issue side
  output logic wb_valid_o, // Destination updated now
  output logic [coproc_timing_pkg::REG_W-1:0] wb_dst_o, // Destination index
  output logic busy_o // Result still in flight
);
  logic [LATENCY-1:0] vld; // Age-indexed valid bits
  logic [coproc_timing_pkg::REG_W-1:0] dst [LATENCY]; // Age-indexed targets
  logic [LATENCY-1:0] next_vld;
  logic [coproc_timing_pkg::REG_W-1:0] next_dst [LATENCY];
  logic hit; // Issue belongs to this class

  assign hit = port.valid && (port.cls == CLASS);

  // Shift toward slot zero, enter at the far end
  always_comb
  begin
    for (int i = 0; i < LATENCY - 1; i++)
    begin
      next_vld[i] = vld[i+1];
      next_dst[i] = dst[i+1];
    end
    next_vld[LATENCY-1] = hit;
    next_dst[LATENCY-1] = port.dst;
  end

  // Register only
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      vld <= '0;
    else
      vld <= next_vld;
    dst <= next_dst;
  end

  assign wb_valid_o = vld[0];
  assign wb_dst_o = dst[0];
  assign busy_o = |vld;

  property p_exact_latency;
    @(posedge core_clk_i) disable iff (rst_i)
    wb_valid_o == $past(hit, LATENCY);
  endproperty
  a_exact_latency: assert property (p_exact_latency)
    else $error("result update not at its latency");
endmodule : result_timer

// *** testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // One table row: opcode and its expected timing
  typedef struct {
    logic [7:0] op;
    int stall;
    int cls;
    int lat;
  } row_t;

  logic core_clk_i = 1'b0; // Core clock
  logic rst_i = 1'b1; // Held high at start
  logic start_i = 1'b0; // Start pulse
  logic [15:0] start_pc_i = 16'h0000; // Entry address
  logic [31:0] instr_i = 32'h00000000; // Word at pc_o
  logic instr_valid_i = 1'b1; // Fetch always ready
  logic jump_taken_i = 1'b0; // Jump condition
  logic xfer_busy_i = 1'b0; // Transfers pending
  logic [15:0] pc_o; // Fetch address
  logic issue_valid_o; // Issue pulse
  logic issue_hold_o; // Issue held
  logic [4:0] wb_valid_o; // Update pulses
  logic [39:0] wb_dst_o; // Update targets
  logic [3:0] lane_mask_o; // Lane mask
  logic idle_o; // Status idle
  int err_count = 0; // Mismatches
  int check_count = 0; // Comparisons
  int cyc = 0; // Cycles run
  row_t rows [16]; // Ordinary cases
  logic [15:0] p; // Pc at last issue
  logic seen; // Result seen in flush

  coproc_issue_stall_timing #(.PC_W(16)) dut (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(start_i),
    .start_pc_i(start_pc_i),
    .instr_i(instr_i),
    .instr_valid_i(instr_valid_i),
    .jump_taken_i(jump_taken_i),
    .xfer_busy_i(xfer_busy_i),
    .pc_o(pc_o),
    .issue_valid_o(issue_valid_o),
    .issue_hold_o(issue_hold_o),
    .wb_valid_o(wb_valid_o),
    .wb_dst_o(wb_dst_o),
    .lane_mask_o(lane_mask_o),
    .idle_o(idle_o)
  );

  // Free running clock, 40 ns period
  always #20 core_clk_i = ~core_clk_i;

  // Cut a hang short; limit is well above the planned run
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      $display("BAD %0t timeout", $time);
      give_verdict();
    end
  end

  // Count one comparison, report on mismatch
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  // Single exit point of the run
  task automatic give_verdict();
    if (err_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // Present a word until it issues; returns at the next falling edge
  // with a no-op already on the bus, so that no-op takes the next slot
  task automatic issue(input logic [31:0] w);
    int n;
    n = 0;
    @(negedge core_clk_i);
    instr_i = w;
    #10;
    while (issue_valid_o !== 1'b1 && n < 40)
    begin
      @(negedge core_clk_i);
      #10;
      n++;
    end
    chk(issue_valid_o === 1'b1, "word not issued");
    p = pc_o;
    @(negedge core_clk_i);
    instr_i = 32'h00000000;
    jump_taken_i = 1'b0;
  endtask : issue

  // Start pulse while idle
  task automatic launch(input logic [15:0] a);
    @(negedge core_clk_i);
    start_i = 1'b1;
    start_pc_i = a;
    @(negedge core_clk_i);
    start_i = 1'b0;
    chk(pc_o === a && idle_o === 1'b0, "start failed");
  endtask : launch

  // After a halt: idle only once the pending result has landed
  task automatic flush(input int b);
    seen = 1'b0;
    repeat (14)
    begin
      #1;
      chk(!(idle_o === 1'b1 && !seen), "idle before flush");
      if (wb_valid_o[b] === 1'b1)
        seen = 1'b1;
      @(negedge core_clk_i);
    end
    chk(idle_o === 1'b1 && seen, "halt never idle");
    p = pc_o;
    repeat (3) @(negedge core_clk_i);
    chk(pc_o === p && issue_valid_o === 1'b0, "ran after halt");
  endtask : flush

  // Main sequence
  initial
  begin
    rows = '{'{8'h01, 0, 0, 6}, '{8'h02, 0, 0, 6}, '{8'h03, 0, 0, 6},
      '{8'h04, 10, 3, 17}, '{8'h05, 0, 2, 9}, '{8'h07, 16, 4, 22},
      '{8'h08, 0, 0, 6}, '{8'h09, 0, 0, 6}, '{8'h0a, 0, 0, 6},
      '{8'h0b, 1, 1, 7}, '{8'h0c, 1, 1, 7}, '{8'h0d, 2, 2, 9},
      '{8'h0e, 0, 0, 6}, '{8'h0f, 0, 0, 6}, '{8'h10, 0, 0, 6},
      '{8'h12, 0, 0, 6}};
    repeat (8) @(negedge core_clk_i);
    chk(pc_o === 16'h0000 && idle_o === 1'b1 && lane_mask_o === 4'hf, "reset state");
    chk(wb_valid_o === 5'h00 && issue_valid_o === 1'b0 && issue_hold_o === 1'b0, "reset outputs");
    rst_i = 1'b0;
    launch(16'h0010);
    // Each op alone: stall length, frozen pc, exact update cycle
    foreach (rows[i])
    begin
      issue({16'h0000, 8'(i + 1), rows[i].op});
      for (int k = 1; k <= rows[i].lat + 1; k++)
      begin
        #1;
        chk(issue_hold_o === (k <= rows[i].stall), "stall length");
        chk(k > rows[i].stall || pc_o === p + 16'h0001, "pc moved");
        chk(wb_valid_o === (k == rows[i].lat ? 5'h01 << rows[i].cls : 5'h00), "wb");
        if (k == rows[i].lat)
          chk(wb_dst_o[8 * rows[i].cls +: 8] === 8'(i + 1), "wb dst");
        @(negedge core_clk_i);
      end
    end
    // Jump taken and not taken; slot always runs
    for (int t = 1; t >= 0; t--)
    begin
      jump_taken_i = t[0];
      issue({8'h00, 16'h0200, 8'h11});
      #1;
      chk(pc_o === p + 16'h0001 && issue_valid_o === 1'b1, "slot");
      @(negedge core_clk_i);
      #1;
      chk(pc_o === (t == 1 ? 16'h0200 : p + 16'h0002), "jump pc");
    end
    // Mask governs the very next word
    issue({20'h00000, 4'h5, 8'h16});
    #1;
    chk(lane_mask_o === 4'h5 && issue_hold_o === 1'b0, "lane mask");
    // Barrier holds while transfers are pending
    issue({8'h00, 16'h0008, 8'h13});
    xfer_busy_i = 1'b1;
    issue({8'h00, 16'h0010, 8'h14});
    issue(32'h00000015);
    repeat (4)
    begin
      #1;
      chk(issue_hold_o === 1'b1 && issue_valid_o === 1'b0, "barrier hold");
      @(negedge core_clk_i);
    end
    xfer_busy_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
    #1;
    chk(issue_hold_o === 1'b0, "barrier stuck");
    // Halt behind a long result, outside any chain
    issue({16'h0000, 8'h44, 8'h04});
    issue(32'h00000017);
    flush(3);
    // Halt inside an accumulate chain; start at slot 0, accumulate at 4
    // Each call takes two slots: its own word and the trailing no-op
    launch(16'h0040);
    issue(32'h00000006);
    issue(32'h00000000);
    issue({16'h0000, 8'h33, 8'h05});
    issue(32'h00000017);
    flush(2);
    // Reset in mid-run clears mask, pc and status
    launch(16'h0080);
    repeat (3) @(negedge core_clk_i);
    rst_i = 1'b1;
    @(negedge core_clk_i);
    chk(pc_o === 16'h0000 && idle_o === 1'b1 && lane_mask_o === 4'hf, "second reset");
    rst_i = 1'b0;
    @(negedge core_clk_i);
    chk(idle_o === 1'b1 && issue_valid_o === 1'b0 && pc_o === 16'h0000, "after reset");
    give_verdict();
  end

endmodule : testbench
